/* hw/lpmcg_div.sv */
// Programmable divider giving a one-cycle enable pulse
`timescale 1ns/1ps
`default_nettype none
module lpmcg_div #(
    parameter int W = 8
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic [W-1:0] div_val,
    output logic tick
);
    // Divider state
    typedef struct packed {
        logic [W-1:0] cnt;
        logic tick;
    } lpmcg_div_type;

    lpmcg_div_type r_ff;
    lpmcg_div_type nxt_r;

    // Count to the divide value; zero stops the output
    always_comb
    begin
        nxt_r = r_ff;
        nxt_r.tick = 1'b0;
        if (!enable || div_val == '0)
        begin
            nxt_r.cnt = '0;
        end
        else if (r_ff.cnt >= div_val - W'(1))
        begin
            nxt_r.cnt = '0;
            nxt_r.tick = 1'b1;
        end
        else
        begin
            nxt_r.cnt = r_ff.cnt + W'(1);
        end
    end

    // State register
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r_ff <= '0;
        end
        else
        begin
            r_ff <= nxt_r;
        end
    end

    assign tick = r_ff.tick;
endmodule // lpmcg_div
`default_nettype wire

/* hw/lpmcg_pkg.sv */
// Constants and types shared by the low power clock gating controller
package lpmcg_pkg;

    // Register byte offsets on the bus
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_GATE = 8'h04;
    localparam logic [7:0] OFS_APD = 8'h08;
    localparam logic [7:0] OFS_SYSCLK = 8'h0c;
    localparam logic [7:0] OFS_PDIV = 8'h10;
    localparam logic [7:0] OFS_WAKE = 8'h14;
    localparam logic [7:0] OFS_STAT = 8'h18;

    // Mode register bit positions
    localparam int MODE_DEEP = 0;
    localparam int MODE_WDOSC = 1;
    localparam int MODE_BROWNOUT = 2;
    localparam int MODE_WDOG_RC = 3;
    localparam int MODE_W = 4;

    // System clock register field positions
    localparam int SRC_LSB = 0;
    localparam int SRC_W = 2;
    localparam int PLL_LSB = 8;
    localparam int PLL_W = 6;
    localparam int CDIV_LSB = 16;
    localparam int DIV_W = 8;

    // Peripheral divider register: two dividers side by side
    localparam int PDIV0_LSB = 0;
    localparam int PDIV1_LSB = 8;
    localparam int NPDIV = 2;

    // Wake enable register: pin mask then watchdog and USB
    localparam int PIN_W = 8;
    localparam int WAKE_WDOG = 8;
    localparam int WAKE_USB = 9;
    localparam int WAKE_W = 10;

    // Reset values
    localparam logic [MODE_W-1:0] MODE_RST = 4'h0;
    localparam logic [DIV_W-1:0] CDIV_RST = 8'h01;
    localparam logic [WAKE_W-1:0] WAKE_RST = 10'h300;

    // Wake cause codes in the status register
    localparam logic [2:0] CAUSE_NONE = 3'h0;
    localparam logic [2:0] CAUSE_PIN = 3'h1;
    localparam logic [2:0] CAUSE_WDOG = 3'h2;
    localparam logic [2:0] CAUSE_USB = 3'h4;

    // Clock source restart settling time
    localparam int SYS_CLK_MHZ = 250;
    localparam int STAB_TIME_NS = 10000;
    localparam int STAB_CYC = (STAB_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
    localparam int STAB_W = 12;

    // Power states
    typedef enum logic [1:0] {
        ST_RUN,
        ST_SLEEP,
        ST_DEEP,
        ST_WAKE
    } lpmcg_state_type;

endpackage

/* hw/lpmcg_top.sv */
// Power mode and clock gating controller with AHB-Lite registers
`timescale 1ns/1ps
`default_nettype none
module lpmcg_top #(
    parameter int NPER = 16,
    parameter int NAPD = 8
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Core side
    input wire logic sleep_req,
    input wire logic irq_pending,
    // Wake sources
    input wire logic [lpmcg_pkg::PIN_W-1:0] wake_pin,
    input wire logic watchdog_irq,
    input wire logic usb_irq,
    // Clock enables and power controls
    output logic core_clk_en,
    output logic bus_mem_clk_en,
    output logic [NPER-1:0] periph_clk_en,
    output logic [lpmcg_pkg::NPDIV-1:0] periph_div_tick,
    output logic [lpmcg_pkg::SRC_W-1:0] clk_src_sel,
    output logic [lpmcg_pkg::PLL_W-1:0] pll_mult,
    output logic rc_osc_out_en,
    output logic sysosc_en,
    output logic pll_en,
    output logic wdosc_en,
    output logic brownout_en,
    output logic [NAPD-1:0] analog_pd,
    output logic flash_standby
);
    import lpmcg_pkg::*;

    // Whole state of the controller
    typedef struct packed {
        lpmcg_state_type st;
        logic [MODE_W-1:0] mode;
        logic [NPER-1:0] gate;
        logic [NAPD-1:0] apd;
        logic [SRC_W-1:0] src;
        logic [PLL_W-1:0] pll;
        logic [DIV_W-1:0] cdiv;
        logic [DIV_W-1:0] pdiv0;
        logic [DIV_W-1:0] pdiv1;
        logic [WAKE_W-1:0] wake;
        logic [2:0] cause;
        logic [STAB_W-1:0] stab;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] hrdata;
        logic hreadyout;
        logic core_en;
        logic busmem_en;
        logic [NPER-1:0] per_en;
        logic rc_en;
        logic sysosc_en;
        logic pll_en;
        logic wdosc_en;
        logic bo_en;
        logic [NAPD-1:0] apd_out;
        logic flash_sb;
    } lpmcg_top_type;

    lpmcg_top_type r_ff;
    lpmcg_top_type nxt_r;

    // Reset release synchroniser
    logic [1:0] rst_sync_ff;
    logic sys_rst_n;

    // Divider pulses
    logic cpu_tick;
    logic [NPDIV-1:0] pdiv_tick;

    // Decoded bus request and wake terms
    logic bus_act;
    logic deep_wake;
    logic [2:0] wake_cause;

    // Register read mux shared by every read
    function automatic logic [31:0] rd_reg(input lpmcg_top_type s,
                                           input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        case (a)
            OFS_MODE: v = 32'(s.mode);
            OFS_GATE: v = 32'(s.gate);
            OFS_APD: v = 32'(s.apd);
            OFS_SYSCLK:
            begin
                v[SRC_LSB +: SRC_W] = s.src;
                v[PLL_LSB +: PLL_W] = s.pll;
                v[CDIV_LSB +: DIV_W] = s.cdiv;
            end
            OFS_PDIV:
            begin
                v[PDIV0_LSB +: DIV_W] = s.pdiv0;
                v[PDIV1_LSB +: DIV_W] = s.pdiv1;
            end
            OFS_WAKE: v = 32'(s.wake);
            OFS_STAT: v = 32'({s.cause, s.st});
            // Unmapped offsets read as zero
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    // Two flops release the asynchronous reset cleanly
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_sync_ff <= 2'b00;
        end
        else
        begin
            rst_sync_ff <= {rst_sync_ff[0], 1'b1};
        end
    end

    assign sys_rst_n = rst_sync_ff[1];

    lpmcg_div #(
        .W(DIV_W)
    ) u_cpu_div (
        .sys_clk(sys_clk),
        .rst_n(sys_rst_n),
        .enable(r_ff.st == ST_RUN),
        .div_val(r_ff.cdiv),
        .tick(cpu_tick)
    );

    // own dividers for selected peripherals, stopped in deep sleep
    lpmcg_div #(
        .W(DIV_W)
    ) u_pdiv0 (
        .sys_clk(sys_clk),
        .rst_n(sys_rst_n),
        .enable(r_ff.per_en[0]),
        .div_val(r_ff.pdiv0),
        .tick(pdiv_tick[0])
    );

    lpmcg_div #(
        .W(DIV_W)
    ) u_pdiv1 (
        .sys_clk(sys_clk),
        .rst_n(sys_rst_n),
        .enable(r_ff.per_en[1]),
        .div_val(r_ff.pdiv1),
        .tick(pdiv_tick[1])
    );

    // Address phase of a selected transfer
    assign bus_act = hsel & hready & htrans[1];

    always_comb
    begin
        wake_cause = CAUSE_NONE;
        if (|(wake_pin & r_ff.wake[PIN_W-1:0]))
        begin
            wake_cause = wake_cause | CAUSE_PIN;
        end
        if (watchdog_irq && r_ff.wake[WAKE_WDOG])
        begin
            wake_cause = wake_cause | CAUSE_WDOG;
        end
        if (usb_irq && r_ff.wake[WAKE_USB])
        begin
            wake_cause = wake_cause | CAUSE_USB;
        end
        deep_wake = |wake_cause;
    end

    // Next state: bus writes, power state machine, output levels
    always_comb
    begin
        nxt_r = r_ff;
        nxt_r.hreadyout = 1'b1;

        // Data phase of a write lands in the registers
        if (r_ff.wr_pend)
        begin
            case (r_ff.wr_addr)
                OFS_MODE: nxt_r.mode = hwdata[MODE_W-1:0];
                OFS_GATE: nxt_r.gate = hwdata[NPER-1:0];
                OFS_APD: nxt_r.apd = hwdata[NAPD-1:0];
                OFS_SYSCLK:
                begin
                    // source, PLL and divider set at run time
                    nxt_r.src = hwdata[SRC_LSB +: SRC_W];
                    nxt_r.pll = hwdata[PLL_LSB +: PLL_W];
                    nxt_r.cdiv = hwdata[CDIV_LSB +: DIV_W];
                end
                OFS_PDIV:
                begin
                    nxt_r.pdiv0 = hwdata[PDIV0_LSB +: DIV_W];
                    nxt_r.pdiv1 = hwdata[PDIV1_LSB +: DIV_W];
                end
                OFS_WAKE: nxt_r.wake = hwdata[WAKE_W-1:0];
                // Read-only and unmapped offsets ignore writes
                default: nxt_r.wake = r_ff.wake;
            endcase
        end

        // Address phase: note a write, answer a read at once
        nxt_r.wr_pend = bus_act & hwrite;
        nxt_r.wr_addr = haddr[7:0];
        if (bus_act && !hwrite)
        begin
            nxt_r.hrdata = rd_reg(nxt_r, haddr[7:0]);
        end

        // Power state machine
        case (r_ff.st)
            ST_RUN:
            begin
                if (sleep_req)
                begin
                    nxt_r.st = r_ff.mode[MODE_DEEP] ? ST_DEEP : ST_SLEEP;
                end
            end
            ST_SLEEP:
            begin
                // exit just reopens the core and bus/memory clocks
                if (irq_pending)
                begin
                    nxt_r.st = ST_RUN;
                end
            end
            ST_DEEP:
            begin
                // leave on an enabled wake event
                if (deep_wake)
                begin
                    nxt_r.st = ST_WAKE;
                    nxt_r.cause = wake_cause;
                    nxt_r.stab = '0;
                end
            end
            ST_WAKE:
            begin
                // sources back on, wait for them to settle
                if (r_ff.stab >= STAB_W'(STAB_CYC - 1))
                begin
                    nxt_r.st = ST_RUN;
                end
                else
                begin
                    nxt_r.stab = r_ff.stab + STAB_W'(1);
                end
            end
            default: nxt_r.st = ST_RUN;
        endcase

        // Run levels by default, then trimmed per state
        nxt_r.core_en = (nxt_r.st == ST_RUN) & cpu_tick;
        nxt_r.busmem_en = 1'b1;
        nxt_r.per_en = nxt_r.gate;
        nxt_r.rc_en = 1'b1;
        nxt_r.sysosc_en = 1'b1;
        nxt_r.pll_en = 1'b1;
        nxt_r.wdosc_en = 1'b1;
        nxt_r.bo_en = 1'b1;
        nxt_r.apd_out = nxt_r.apd;
        nxt_r.flash_sb = 1'b0;

        case (nxt_r.st)
            ST_SLEEP:
            begin
                // memories and buses go quiet too
                nxt_r.busmem_en = 1'b0;
                nxt_r.per_en = nxt_r.gate;
            end
            ST_DEEP:
            begin
                // all peripheral clocks, system oscillator and PLL off
                nxt_r.busmem_en = 1'b0;
                nxt_r.per_en = '0;
                nxt_r.sysosc_en = 1'b0;
                nxt_r.pll_en = 1'b0;
                // RC output only when it feeds the watchdog
                nxt_r.rc_en = nxt_r.mode[MODE_WDOG_RC];
                nxt_r.wdosc_en = nxt_r.mode[MODE_WDOSC];
                nxt_r.bo_en = nxt_r.mode[MODE_BROWNOUT];
                nxt_r.apd_out = '1;
                nxt_r.flash_sb = 1'b1;
            end
            ST_WAKE:
            begin
                // core and peripherals wait for settling
                nxt_r.busmem_en = 1'b0;
                nxt_r.per_en = '0;
            end
            default: nxt_r.flash_sb = 1'b0;
        endcase
    end

    // Single state register
    always_ff @(posedge sys_clk or negedge sys_rst_n)
    begin
        if (!sys_rst_n)
        begin
            r_ff <= '0;
            r_ff.st <= ST_RUN;
            r_ff.mode <= MODE_RST;
            r_ff.gate <= '1;
            r_ff.cdiv <= CDIV_RST;
            r_ff.wake <= WAKE_RST;
            r_ff.hreadyout <= 1'b1;
            r_ff.busmem_en <= 1'b1;
            r_ff.per_en <= '1;
            r_ff.rc_en <= 1'b1;
            r_ff.sysosc_en <= 1'b1;
            r_ff.pll_en <= 1'b1;
            r_ff.wdosc_en <= 1'b1;
            r_ff.bo_en <= 1'b1;
        end
        else
        begin
            r_ff <= nxt_r;
        end
    end

    // Ports straight from the state register, bar hresp and the divider ticks
    assign hrdata = r_ff.hrdata;
    assign hreadyout = r_ff.hreadyout;
    assign hresp = 1'b0;
    assign core_clk_en = r_ff.core_en;
    assign bus_mem_clk_en = r_ff.busmem_en;
    assign periph_clk_en = r_ff.per_en;
    assign periph_div_tick = pdiv_tick;
    assign clk_src_sel = r_ff.src;
    assign pll_mult = r_ff.pll;
    assign rc_osc_out_en = r_ff.rc_en;
    assign sysosc_en = r_ff.sysosc_en;
    assign pll_en = r_ff.pll_en;
    assign wdosc_en = r_ff.wdosc_en;
    assign brownout_en = r_ff.bo_en;
    assign analog_pd = r_ff.apd_out;
    assign flash_standby = r_ff.flash_sb;

    // hsize is accepted but only whole words are meaningful
    logic unused_ok;
    assign unused_ok = ^{hsize, haddr[31:8]};
endmodule // lpmcg_top
`default_nettype wire

/* tb/lpmcg_assertions.sv */
// Port checker for the power mode and clock gating controller
`timescale 1ns/1ps
`default_nettype none
module lpmcg_assertions #(
    parameter int NPER = 16,
    parameter int NAPD = 8
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic sleep_req,
    input wire logic irq_pending,
    input wire logic [lpmcg_pkg::PIN_W-1:0] wake_pin,
    input wire logic watchdog_irq,
    input wire logic usb_irq,
    input wire logic core_clk_en,
    input wire logic bus_mem_clk_en,
    input wire logic [NPER-1:0] periph_clk_en,
    input wire logic sysosc_en,
    input wire logic pll_en,
    input wire logic [NAPD-1:0] analog_pd,
    input wire logic flash_standby
);
    import lpmcg_pkg::*;
    // Set on deep entry, cleared once the bus clock is back
    logic deep_ff;
    // Cycles spent settling after a deep wake
    logic [STAB_W-1:0] wcnt_ff;
    // Track the deep path and count the settling cycles
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            deep_ff <= 1'b0;
            wcnt_ff <= '0;
        end
        else
        begin
            deep_ff <= flash_standby | (deep_ff & ~bus_mem_clk_en);
            if (deep_ff & ~flash_standby & ~bus_mem_clk_en)
                wcnt_ff <= wcnt_ff + STAB_W'(1);
            else
                wcnt_ff <= '0;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    property p_sleep_entry;
        bus_mem_clk_en && sleep_req |=> !core_clk_en && !bus_mem_clk_en;
    endproperty
    a_sleep_entry: assert property (p_sleep_entry)
        else $error("core or bus clock kept on sleep entry");
    property p_periph_kept;
        bus_mem_clk_en && sleep_req |=>
            flash_standby || periph_clk_en == $past(periph_clk_en);
    endproperty
    a_periph_kept: assert property (p_periph_kept)
        else $error("peripheral clocks changed on sleep entry");
    property p_sleep_hold;
        !bus_mem_clk_en && !deep_ff && !flash_standby && !irq_pending
            |=> !core_clk_en;
    endproperty
    a_sleep_hold: assert property (p_sleep_hold)
        else $error("core clocked in sleep without interrupt");
    property p_sleep_wake;
        !bus_mem_clk_en && !deep_ff && !flash_standby && irq_pending
            |=> bus_mem_clk_en;
    endproperty
    a_sleep_wake: assert property (p_sleep_wake)
        else $error("sleep not left one cycle after interrupt");
    property p_deep_off;
        flash_standby |-> periph_clk_en == '0 && !sysosc_en && !pll_en
            && !core_clk_en && !bus_mem_clk_en;
    endproperty
    a_deep_off: assert property (p_deep_off)
        else $error("clock left running in deep sleep");
    property p_deep_analog;
        flash_standby |-> &analog_pd;
    endproperty
    a_deep_analog: assert property (p_deep_analog)
        else $error("analog block powered in deep sleep");
    property p_deep_hold;
        flash_standby && !(|wake_pin) && !watchdog_irq && !usb_irq
            |=> flash_standby;
    endproperty
    a_deep_hold: assert property (p_deep_hold)
        else $error("deep sleep left without wake source");
    property p_wake_core_off;
        $fell(flash_standby) |-> !core_clk_en[*8];
    endproperty
    a_wake_core_off: assert property (p_wake_core_off)
        else $error("core clock back before sources settled");
    property p_wake_settle;
        $rose(bus_mem_clk_en) && deep_ff |-> wcnt_ff inside {[2499:2501]};
    endproperty
    a_wake_settle: assert property (p_wake_settle)
        else $error("settling time after deep wake is wrong");
    c_sleep: cover property (bus_mem_clk_en && sleep_req ##1 !flash_standby);
    c_deep: cover property ($rose(flash_standby));
    c_wake: cover property ($rose(bus_mem_clk_en) && deep_ff);
endmodule // lpmcg_assertions

bind lpmcg_top lpmcg_assertions #(.NPER(NPER), .NAPD(NAPD))
    u_lpmcg_assertions (.sys_clk, .rst_n, .sleep_req, .irq_pending,
    .wake_pin, .watchdog_irq, .usb_irq, .core_clk_en, .bus_mem_clk_en,
    .periph_clk_en, .sysosc_en, .pll_en, .analog_pd, .flash_standby);
`default_nettype wire

/* tb/lpmcg_far_model.sv */
// Core and peripheral stand-in facing the controller
`timescale 1ns/1ps
`default_nettype none
module lpmcg_far_model (
    input wire logic sys_clk,
    input wire logic core_clk_en,
    input wire logic sleep_cmd,
    input wire logic irq_cmd,
    output var logic sleep_req,
    output var logic irq_pending,
    output var logic [15:0] core_ticks
);
    // Idle core with no request pending
    initial
    begin
        sleep_req = 1'b0;
        irq_pending = 1'b0;
        core_ticks = '0;
    end
    // Core acts only on its own clock ticks
    always @(posedge sys_clk)
    begin
        // Sleep instruction is issued only while executing
        sleep_req <= sleep_cmd && core_clk_en && !sleep_req;
        // Peripheral holds its interrupt until the core runs
        irq_pending <= irq_cmd || (irq_pending && !core_clk_en);
        core_ticks <= core_ticks + 16'(core_clk_en);
    end
endmodule // lpmcg_far_model
`default_nettype wire

/* tb/lpmcg_top_tb.sv */
// Self-checking bench for the power mode controller
`timescale 1ns/1ps
`default_nettype none
module lpmcg_top_tb;
    import lpmcg_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0] htrans = '0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = '0;
    logic [PIN_W-1:0] wake_pin = '0;
    logic watchdog_irq = 1'b0;
    logic usb_irq = 1'b0;
    logic sleep_cmd = 1'b0;
    logic irq_cmd = 1'b0;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, sleep_req, irq_pending, core_clk_en;
    logic bus_mem_clk_en, rc_osc_out_en, sysosc_en, pll_en, wdosc_en;
    logic brownout_en, flash_standby;
    logic [15:0] periph_clk_en, core_ticks, t0;
    logic [NPDIV-1:0] periph_div_tick;
    logic [SRC_W-1:0] clk_src_sel;
    logic [PLL_W-1:0] pll_mult;
    logic [7:0] analog_pd;
    int error_cnt = 0;
    int checks = 0;
    int n0, n1;
    // Register reset values, last entry unmapped
    logic [31:0] rst_tab [8] = '{'0, 32'hffff, '0, 32'h10000, '0,
        32'h300, '0, '0};
    // Per deep case: mode, wake mask, masked and enabled sources
    logic [3:0] dmode [2] = '{4'hb, 4'h5};
    logic [9:0] wmsk [2] = '{10'h001, 10'h300};
    logic [9:0] bad [2] = '{10'h102, 10'h001};
    logic [9:0] good [2] = '{10'h001, 10'h300};
    logic [31:0] kept [2] = '{32'h6, 32'h1};
    logic [31:0] stat [2] = '{32'h04, 32'h18};
    // 250 MHz clock
    always #2 sys_clk = ~sys_clk;
    lpmcg_top u_lpmcg_top (.sys_clk, .rst_n, .hsel, .haddr, .htrans,
        .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
        .hreadyout, .hresp, .sleep_req, .irq_pending, .wake_pin,
        .watchdog_irq, .usb_irq, .core_clk_en, .bus_mem_clk_en,
        .periph_clk_en, .periph_div_tick, .clk_src_sel, .pll_mult,
        .rc_osc_out_en, .sysosc_en, .pll_en, .wdosc_en, .brownout_en,
        .analog_pd, .flash_standby);
    lpmcg_far_model u_lpmcg_far_model (.sys_clk, .core_clk_en, .sleep_cmd,
        .irq_cmd, .sleep_req, .irq_pending, .core_ticks);
    // Compare one value and count it
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h, want %h", $time, got, exp);
        end
    endtask
    // One single AHB-Lite word transfer
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    // Read a register and compare it
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, '0);
        chk(rd, e);
    endtask
    // Wait for the bus clock enable to reach a level, bounded
    task automatic wait_bus(input logic v);
        for (int i = 0; i < 3000 && bus_mem_clk_en !== v; i++)
            @(posedge sys_clk);
        chk(32'(bus_mem_clk_en), 32'(v));
    endtask
    // Count divider ticks over n cycles
    task automatic cnt(input int n);
        n0 = 0;
        n1 = 0;
        t0 = core_ticks;
        repeat (n)
        begin
            @(posedge sys_clk);
            n0 += int'(periph_div_tick[0]);
            n1 += int'(periph_div_tick[1]);
        end
    endtask
    // Print counts and verdict, then stop
    task automatic wrap_up();
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Main test sequence
    initial
    begin
        repeat (5) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        for (int i = 0; i < 8; i++)
            rdchk(8'(i * 4), rst_tab[i]);
        chk(32'({hreadyout, hresp}), 32'h2);
        xfer(1'b1, OFS_GATE, 32'h00a5);
        rdchk(OFS_GATE, 32'h00a5);
        xfer(1'b1, OFS_APD, 32'h005a);
        xfer(1'b1, OFS_PDIV, 32'h0203);
        xfer(1'b1, OFS_SYSCLK, 32'h00040502);
        rdchk(OFS_SYSCLK, 32'h00040502);
        chk(32'({clk_src_sel, pll_mult}), 32'h85);
        chk(32'(periph_clk_en), 32'h00a5);
        chk(32'(analog_pd), 32'h5a);
        repeat (10) @(posedge sys_clk);
        cnt(60);
        chk(32'(n0), 32'd20);
        chk(32'(n1), 32'd0);
        chk(32'(core_ticks - t0), 32'd15);
        // Light sleep and interrupt wake
        sleep_cmd <= 1'b1;
        wait_bus(1'b0);
        sleep_cmd <= 1'b0;
        cnt(30);
        chk(32'(core_ticks - t0), 32'd0);
        chk(32'(n0), 32'd10);
        rdchk(OFS_STAT, 32'h1);
        irq_cmd <= 1'b1;
        @(posedge sys_clk);
        irq_cmd <= 1'b0;
        wait_bus(1'b1);
        // Deep sleep, masked then enabled wake source
        for (int k = 0; k < 2; k++)
        begin
            xfer(1'b1, OFS_WAKE, 32'(wmsk[k]));
            xfer(1'b1, OFS_MODE, 32'(dmode[k]));
            sleep_cmd <= 1'b1;
            wait_bus(1'b0);
            sleep_cmd <= 1'b0;
            repeat (3) @(posedge sys_clk);
            chk(32'({flash_standby, sysosc_en, pll_en}), 32'h4);
            chk(32'(analog_pd), 32'hff);
            chk(32'(periph_clk_en), 32'h0);
            chk(32'({rc_osc_out_en, wdosc_en, brownout_en}), kept[k]);
            cnt(30);
            chk(32'(n0), 32'd0);
            chk(32'(core_ticks - t0), 32'd0);
            irq_cmd <= 1'b1;
            {usb_irq, watchdog_irq, wake_pin} <= bad[k];
            repeat (10) @(posedge sys_clk);
            irq_cmd <= 1'b0;
            chk(32'(flash_standby), 32'h1);
            {usb_irq, watchdog_irq, wake_pin} <= good[k];
            repeat (3) @(posedge sys_clk);
            {usb_irq, watchdog_irq, wake_pin} <= '0;
            chk(32'(flash_standby), 32'h0);
            wait_bus(1'b1);
            chk(32'({sysosc_en, pll_en, periph_clk_en}), 32'h300a5);
            chk(32'({rc_osc_out_en, analog_pd}), 32'h15a);
            rdchk(OFS_STAT, stat[k]);
        end
        wrap_up();
    end
    // Watchdog against a hang
    initial
    begin
        #(4 * 20000);
        error_cnt++;
        wrap_up();
    end
endmodule // lpmcg_top_tb
`default_nettype wire
